// File: snva_pkg.sv
// Constants and types shared by the serial nonvolatile memory access block
package snva_pkg;
	localparam int ADDR_W          = 9;         // Nine-bit byte address
	localparam int MEM_DEPTH       = 512;       // Bytes in the array
	localparam logic [2:0] BIT_LAST = 3'h7;     // Index of eighth bit in a byte
	localparam logic [7:0] CMD_SET_WL   = 8'h06; // write_latch_set_cmd
	localparam logic [7:0] CMD_CLR_WL   = 8'h04; // Write latch clear command
	localparam logic [7:0] CMD_RD_STAT  = 8'h05; // Status read command
	localparam logic [7:0] CMD_WR_STAT  = 8'h01; // Status write command
	localparam logic [7:0] CMD_MEM_MASK = 8'hf7; // Opcode mask hiding addr_msb
	localparam logic [7:0] CMD_MEM_WR   = 8'h02; // Memory write, masked form
	localparam logic [7:0] CMD_MEM_RD   = 8'h03; // Memory read, masked form
	localparam int CMD_AMSB_POS    = 3;         // Opcode bit carrying addr_msb
	localparam int STAT_BP_LO_POS  = 2;         // protect_range_lo in status byte
	localparam int STAT_BP_HI_POS  = 3;         // protect_range_hi in status byte
	localparam int STAT_WL_POS     = 1;         // write_latch_flag in status byte
	localparam logic [8:0] PROT_QTR_BASE = 9'h180; // Upper quarter start
	localparam logic [8:0] PROT_HALF_BASE = 9'h100; // Upper half start
	localparam logic [1:0] PROT_RST = 2'h0;     // Block protect at reset

	typedef enum logic [2:0] {
		SNVA_IDLE = 3'b000,
		SNVA_CMD  = 3'b001,
		SNVA_ADR  = 3'b011,
		SNVA_WDAT = 3'b010,
		SNVA_RDAT = 3'b110,
		SNVA_STAT = 3'b111,
		SNVA_SKIP = 3'b101
	} snva_state_e;
endpackage : snva_pkg

// File: snva_sync.sv
// Three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module snva_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk_i,  // System clock
	input  wire logic nrst_i, // Synchronous reset, active low
	input  wire logic ce_i,   // Clock enable
	input  wire logic pin_i,  // Asynchronous pin
	output logic      lvl_o   // Filtered level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// Shift chain; level changes once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			s1_r  <= RST_VAL;
			s2_r  <= RST_VAL;
			s3_r  <= RST_VAL;
			lvl_o <= RST_VAL;
		end else if (ce_i) begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				lvl_o <= s3_r;
			end
		end
	end
endmodule : snva_sync

// File: snva_core.sv
// SPI slave sequencing for a 512-byte serial nonvolatile memory
`timescale 1ns/1ps
module snva_core (
	input  wire logic clk_i,      // 250 MHz system clock
	input  wire logic nrst_i,     // Synchronous reset, active low
	input  wire logic ce_i,       // Clock enable, freezes state when low
	input  wire logic sel_n_i,    // Chip select pin, active low
	input  wire logic sck_i,      // Serial clock pin
	input  wire logic sdi_i,      // Serial data in pin
	input  wire logic pause_n_i,  // Pause pin, active low
	input  wire logic wprot_n_i,  // Write protect pin, active low
	output logic      sdo_o,      // Serial data out value
	output logic      sdo_oe_o,   // Serial data out enable
	output logic      write_latch_flag_o, // Write latch state
	output logic [1:0] protect_range_o     // Block protect bits hi,lo
);
	import snva_pkg::*;

	logic sel_n_s, sck_s, sdi_s, pause_n_s, wprot_n_s;
	logic sck_d_r;
	logic paused_r;
	snva_state_e state_r;
	logic [2:0] bit_r;
	logic [7:0] sh_r;
	logic [8:0] addr_r;
	logic is_wr_r;
	logic [7:0] mem [MEM_DEPTH];
	logic [7:0] out_byte_r;
	logic write_latch_flag_r;
	logic [1:0] protect_range_r;
	logic wrote_r;

	snva_sync #(.RST_VAL(1'b1)) u_sel (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.pin_i(sel_n_i), .lvl_o(sel_n_s));
	snva_sync #(.RST_VAL(1'b0)) u_sck (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.pin_i(sck_i), .lvl_o(sck_s));
	snva_sync #(.RST_VAL(1'b0)) u_sdi (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.pin_i(sdi_i), .lvl_o(sdi_s));
	snva_sync #(.RST_VAL(1'b1)) u_pau (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.pin_i(pause_n_i), .lvl_o(pause_n_s));
	snva_sync #(.RST_VAL(1'b1)) u_wp (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.pin_i(wprot_n_i), .lvl_o(wprot_n_s));

	// Protection check for one address
	function automatic logic addr_prot(input logic [8:0] a, input logic [1:0] bp);
		unique case (bp)
			2'h0: addr_prot = 1'b0;
			2'h1: addr_prot = (a >= PROT_QTR_BASE);
			2'h2: addr_prot = (a >= PROT_HALF_BASE);
			2'h3: addr_prot = 1'b1;
		endcase
	endfunction : addr_prot

	logic rise, fall, byte_done, active;
	logic [7:0] byte_in;
	assign active    = !sel_n_s && !paused_r;
	assign rise      = active && sck_s && !sck_d_r;
	assign fall      = active && !sck_s && sck_d_r;
	assign byte_done = rise && (bit_r == BIT_LAST);
	assign byte_in   = {sh_r[6:0], sdi_s};

	// Clock edge history
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			sck_d_r <= 1'b0;
		end else if (ce_i) begin
			sck_d_r <= sck_s;
		end
	end

	// Pause enters and leaves with clock low; deselect clears it at any clock level
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			paused_r <= 1'b0;
		end else if (ce_i) begin
			if (sel_n_s) begin
				paused_r <= 1'b0;
			end else if (!sck_s) begin
				paused_r <= !pause_n_s;
			end
		end
	end

	// Bit counter and input shifter; deselect drops a partial byte
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			bit_r <= 3'h0;
			sh_r  <= 8'h00;
		end else if (ce_i) begin
			if (sel_n_s) begin
				bit_r <= 3'h0;
			end else if (rise) begin
				bit_r <= bit_r + 3'h1;
				sh_r  <= byte_in;
			end
		end
	end

	// Command sequencing state machine
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state_r <= SNVA_IDLE;
			is_wr_r <= 1'b0;
		end else if (ce_i) begin
			if (sel_n_s) begin
				state_r <= SNVA_IDLE;
			end else begin
				unique case (state_r)
					SNVA_IDLE: state_r <= SNVA_CMD;
					SNVA_CMD: if (byte_done) begin
						if ((byte_in & CMD_MEM_MASK) == CMD_MEM_WR) begin
							state_r <= SNVA_ADR;
							is_wr_r <= 1'b1;
						end else if ((byte_in & CMD_MEM_MASK) == CMD_MEM_RD) begin
							state_r <= SNVA_ADR;
							is_wr_r <= 1'b0;
						end else if (byte_in == CMD_RD_STAT || byte_in == CMD_WR_STAT) begin
							state_r <= SNVA_STAT;
							is_wr_r <= (byte_in == CMD_WR_STAT);
						end else begin
							state_r <= SNVA_SKIP;
						end
					end
					SNVA_ADR: if (byte_done) begin
						state_r <= is_wr_r ? SNVA_WDAT : SNVA_RDAT;
					end
					SNVA_STAT: if (byte_done) begin
						state_r <= SNVA_SKIP;
					end
					SNVA_WDAT, SNVA_RDAT, SNVA_SKIP: state_r <= state_r;
					default: state_r <= SNVA_IDLE;
				endcase
			end
		end
	end

	// Address counter with load and wrap
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			addr_r <= 9'h000;
		end else if (ce_i && byte_done) begin
			if (state_r == SNVA_CMD) begin
				addr_r[8] <= byte_in[CMD_AMSB_POS];
			end else if (state_r == SNVA_ADR) begin
				addr_r[7:0] <= byte_in;
			end else if (state_r == SNVA_WDAT || state_r == SNVA_RDAT) begin
				addr_r <= addr_r + 9'h001;
			end
		end
	end

	// Array store right after the eighth bit
	always_ff @(posedge clk_i) begin
		if (ce_i && byte_done && state_r == SNVA_WDAT && write_latch_flag_r && wprot_n_s
				&& !addr_prot(addr_r, protect_range_r)) begin
			mem[addr_r] <= byte_in;
		end
	end

	// Write latch, status bits and write-frame tracking
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			write_latch_flag_r <= 1'b0;
			protect_range_r    <= PROT_RST;
			wrote_r            <= 1'b0;
		end else if (ce_i) begin
			if (sel_n_s) begin
				if (wrote_r) begin
					write_latch_flag_r <= 1'b0;
				end
				wrote_r <= 1'b0;
			end else if (byte_done) begin
				if (state_r == SNVA_CMD && byte_in == CMD_SET_WL) begin
					write_latch_flag_r <= 1'b1;
				end else if (state_r == SNVA_CMD && byte_in == CMD_CLR_WL) begin
					write_latch_flag_r <= 1'b0;
				end else if (state_r == SNVA_CMD && (byte_in & CMD_MEM_MASK) == CMD_MEM_WR) begin
					wrote_r <= 1'b1;
				end else if (state_r == SNVA_STAT && is_wr_r) begin
					wrote_r <= 1'b1;
					if (write_latch_flag_r && wprot_n_s) begin
						protect_range_r <= {byte_in[STAT_BP_HI_POS], byte_in[STAT_BP_LO_POS]};
					end
				end
			end
		end
	end

	// Output byte load on the eighth rising edge, shift on falling edges; input ignored in read
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			out_byte_r <= 8'h00;
			sdo_o      <= 1'b0;
		end else if (ce_i) begin
			if (byte_done && state_r == SNVA_ADR && !is_wr_r) begin
				out_byte_r <= mem[{addr_r[8], byte_in}];
			end else if (byte_done && state_r == SNVA_RDAT) begin
				out_byte_r <= mem[addr_r + 9'h001];
			end else if (byte_done && state_r == SNVA_CMD && byte_in == CMD_RD_STAT) begin
				out_byte_r <= 8'h00;
				out_byte_r[STAT_WL_POS]    <= write_latch_flag_r;
				out_byte_r[STAT_BP_LO_POS] <= protect_range_r[0];
				out_byte_r[STAT_BP_HI_POS] <= protect_range_r[1];
			end
			if (fall && (state_r == SNVA_RDAT || (state_r == SNVA_STAT && !is_wr_r))) begin
				sdo_o <= out_byte_r[BIT_LAST - bit_r];
			end
		end
	end

	// Output enable released on deselect or pause
	assign sdo_oe_o = !sel_n_s && !paused_r && pause_n_s &&
		(state_r == SNVA_RDAT || (state_r == SNVA_STAT && !is_wr_r));
	assign write_latch_flag_o = write_latch_flag_r;
	assign protect_range_o    = protect_range_r;

	// Guards on output release, pause freeze, address handling and latch clearing
	chk_pause_hiz: assert property (@(posedge clk_i) disable iff (!nrst_i)
		paused_r |-> !sdo_oe_o) else $error("output driven while paused");
	chk_desel_hiz: assert property (@(posedge clk_i) disable iff (!nrst_i)
		sel_n_s |-> !sdo_oe_o) else $error("output driven while deselected");
	chk_pause_freeze: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(ce_i && paused_r && !sel_n_s) |=> ($stable(bit_r) && $stable(addr_r)))
		else $error("state moved during pause");
	chk_addr_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(ce_i && byte_done && state_r == SNVA_WDAT) |=> addr_r == $past(addr_r) + 9'h001)
		else $error("write address did not advance");
	chk_latch_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(ce_i && sel_n_s && wrote_r) |=> !write_latch_flag_r)
		else $error("latch kept after write frame");
	chk_desel_reset: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(ce_i && sel_n_s) |=> (bit_r == 3'h0 && state_r == SNVA_IDLE))
		else $error("partial byte survived deselect");
	chk_msb_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(ce_i && byte_done && state_r == SNVA_CMD) |=> addr_r[8] == sh_r[CMD_AMSB_POS])
		else $error("address msb not taken from the command byte");
	chk_wrap: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(ce_i && byte_done && state_r == SNVA_RDAT && addr_r == 9'h1ff) |=> addr_r == 9'h000)
		else $error("address did not wrap");
endmodule : snva_core

// File: snva_mst.sv
// SPI master model driving the memory pins in mode 0 or mode 3
`timescale 1ns/1ps
module snva_mst (
	input  wire logic clk_i,     // System clock, keeps pin changes off its edges
	input  wire logic miso_i,    // Data from device
	output logic      sel_n_o,   // Select, active low
	output logic      sck_o,     // Serial clock
	output logic      sdi_o,     // Data to device
	output logic      pause_n_o  // Pause, active low
);
	localparam realtime HALF = 62.5; // Half of 125 ns
	localparam realtime SKEW = 0.25; // Offset from the falling system clock edge
	logic               mode3;      // Serial clock idles high when set

	// Idle levels, clock still between frames
	initial begin
		mode3 = 1'b0;
		sel_n_o = 1'b1;
		sck_o = 1'b0;
		sdi_o = 1'b0;
		pause_n_o = 1'b1;
	end

	// Park the clock at its idle level, select, and wait out the setup time;
	// the quarter-nanosecond skew keeps every pin change off a system clock edge
	task automatic open_frame();
		@(negedge clk_i);
		#(SKEW);
		sck_o = mode3;
		#(HALF);
		sel_n_o = 1'b0;
		#(HALF);
	endtask : open_frame

	// Deselect, which ends the frame and drops a partial byte
	task automatic close_frame();
		#(HALF);
		sel_n_o = 1'b1;
		sdi_o = ~sdi_o;
		#(4 * HALF);
	endtask : close_frame

	// Send the top nb bits MSB first, reply sampled at each rise
	task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nb; i--) begin
			if (mode3) sck_o = 1'b0;
			sdi_o = tx[i];
			#(HALF);
			sck_o = 1'b1;
			rx[i] = miso_i;
			#(HALF);
			if (!mode3) sck_o = 1'b0;
		end
	endtask : shift

	// Pause and resume with clock low, toggling the clock meanwhile
	task automatic pause_span(input int nt);
		#(HALF);
		pause_n_o = 1'b0;
		repeat (2 * nt) begin
			#(HALF);
			sck_o = ~sck_o;
		end
		#(HALF);
		pause_n_o = 1'b1;
		#(HALF);
	endtask : pause_span
endmodule : snva_mst

// File: tb_serial_nv_memory_access.sv
// Self-checking bench for the serial memory access block
`timescale 1ns/1ps
module tb_serial_nv_memory_access;
	import snva_pkg::*;
	logic       clk_i, nrst_i, wprot_n_i, sel_n, sck, sdi, pause_n, sdo_o, sdo_oe_o, flip_r;
	logic       write_latch_flag_o, ce_i;
	logic [1:0] protect_range_o, bp_exp;
	logic [7:0] mem_exp [MEM_DEPTH];
	logic       wl_exp;
	wire        miso = sdo_oe_o ? sdo_o : flip_r;
	int         err_count, samples_checked, cyc, seed, pz_cnt;
	logic [8:0] starts [3] = '{9'h0ff, 9'h17f, 9'h1ff};

	snva_core i_snva_core (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .sel_n_i(sel_n),
		.sck_i(sck), .sdi_i(sdi), .pause_n_i(pause_n), .wprot_n_i(wprot_n_i), .sdo_o(sdo_o),
		.sdo_oe_o(sdo_oe_o), .write_latch_flag_o(write_latch_flag_o),
		.protect_range_o(protect_range_o));
	snva_mst i_snva_mst (.clk_i(clk_i), .miso_i(miso), .sel_n_o(sel_n), .sck_o(sck), .sdi_o(sdi),
		.pause_n_o(pause_n));

	// Clock, idle-line pattern, timeout and pause watch
	always #2 clk_i = ~clk_i;
	// Clock enable drops at random in about one cycle of eight once reset is over
	always @(negedge clk_i) begin
		if (nrst_i) begin
			ce_i <= ($random(seed) & 7) != 0;
		end else begin
			ce_i <= 1'b1;
		end
	end
	always @(posedge clk_i) begin
		flip_r <= ~flip_r;
		cyc++;
		pz_cnt <= pause_n ? 0 : pz_cnt + 1;
		if (pz_cnt == 16) check({7'h0, sdo_oe_o}, 8'h00);
		if (cyc == 95000) begin
			err_count++;
			close_out();
		end
	end

	// Expected protection of one address
	function automatic logic guarded(input logic [1:0] bp, input logic [8:0] a);
		return (bp == 2'h3) || (bp == 2'h2 && a >= PROT_HALF_BASE) || (bp == 2'h1 && a >= PROT_QTR_BASE);
	endfunction : guarded

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Frame of opcode plus optional byte; reply returned
	task automatic frame(input logic [7:0] op, input int nb, input logic [7:0] d, output logic [7:0] rx);
		i_snva_mst.open_frame();
		i_snva_mst.shift(op, 8, rx);
		if (nb > 0) i_snva_mst.shift(d, nb, rx);
		i_snva_mst.close_frame();
	endtask : frame

	task automatic latch(input logic [7:0] op);
		logic [7:0] rx;
		frame(op, 0, 8'h00, rx);
		wl_exp = (op == CMD_SET_WL);
		check({7'h0, write_latch_flag_o}, {7'h0, wl_exp});
	endtask : latch

	task automatic stat(input int wr, input logic [1:0] bp);
		logic [7:0] rx;
		if (wr) begin
			frame(CMD_WR_STAT, 8, {4'h0, bp, 2'h0}, rx);
			bp_exp = bp;
			wl_exp = 1'b0;
			check({6'h0, protect_range_o}, {6'h0, bp_exp});
		end
		frame(CMD_RD_STAT, 8, 8'h00, rx);
		check(rx, {4'h0, bp_exp, wl_exp, 1'b0});
	endtask : stat

	// Write n bytes then part bits of one more
	task automatic mem_write(input logic [8:0] a, input int n, input int part);
		logic [7:0] rx, d;
		i_snva_mst.open_frame();
		i_snva_mst.shift(CMD_MEM_WR | {4'h0, a[8], 3'h0}, 8, rx);
		i_snva_mst.shift(a[7:0], 8, rx);
		for (int k = 0; k < n; k++) begin
			d = 8'($random(seed));
			i_snva_mst.shift(d, 8, rx);
			if (wl_exp && wprot_n_i && !guarded(bp_exp, a)) mem_exp[a] = d;
			a = a + 9'h001;
		end
		if (part > 0) i_snva_mst.shift(8'($random(seed)), part, rx);
		i_snva_mst.close_frame();
		wl_exp = 1'b0;
		check({7'h0, write_latch_flag_o}, {7'h0, wl_exp});
	endtask : mem_write

	// Read n bytes with random input during data, optional pause
	task automatic mem_read(input logic [8:0] a, input int n, input int pz);
		logic [7:0] rx;
		i_snva_mst.open_frame();
		i_snva_mst.shift(CMD_MEM_RD | {4'h0, a[8], 3'h0}, 8, rx);
		i_snva_mst.shift(a[7:0], 8, rx);
		for (int k = 0; k < n; k++) begin
			i_snva_mst.shift(8'($random(seed)), 8, rx);
			if (!$isunknown(mem_exp[a])) check(rx, mem_exp[a]);
			a = a + 9'h001;
			if (pz && k == 0) begin
				i_snva_mst.pause_span(3);
				check({7'h0, sdo_oe_o}, 8'h01);
			end
		end
		i_snva_mst.close_frame();
		check({7'h0, sdo_oe_o}, 8'h00);
	endtask : mem_read

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	// Main sequence
	initial begin
		clk_i = 1'b0;
		nrst_i = 1'b0;
		wprot_n_i = 1'b1;
		flip_r = 1'b0;
		seed = 23;
		wl_exp = 1'b0;
		bp_exp = PROT_RST;
		repeat (5) @(negedge clk_i);
		nrst_i = 1'b1;
		@(negedge clk_i);
		check({5'h0, protect_range_o, write_latch_flag_o, sdo_oe_o}, 8'h00);
		latch(CMD_SET_WL);
		mem_write(9'h1fe, 5, 0);
		latch(CMD_SET_WL);
		mem_write(9'h1fe, 2, 5);
		mem_read(9'h1fe, 5, 1);
		$display("test wrap and pause done");
		mem_write(9'h000, 2, 0);
		latch(CMD_SET_WL);
		@(negedge clk_i);
		wprot_n_i = 1'b0;
		mem_write(9'h001, 2, 0);
		@(negedge clk_i);
		wprot_n_i = 1'b1;
		latch(CMD_CLR_WL);
		stat(0, 2'h0);
		mem_read(9'h1fe, 5, 0);
		$display("test refused writes done");
		for (int b = 0; b < 4; b++) begin
			latch(CMD_SET_WL);
			stat(1, 2'(b));
			foreach (starts[s]) begin
				latch(CMD_SET_WL);
				mem_write(starts[s], 2, 0);
			end
			foreach (starts[s]) mem_read(starts[s], 2, 0);
		end
		latch(CMD_SET_WL);
		stat(1, 2'h0);
		$display("test protect ranges done");
		i_snva_mst.mode3 = 1'b1;
		repeat (3) begin
			latch(CMD_SET_WL);
			starts[0] = 9'($random(seed));
			mem_write(starts[0], 1 + ($random(seed) & 3), 0);
			mem_read(starts[0], 4, 0);
		end
		$display("test random frames done");
		close_out();
	end
endmodule : tb_serial_nv_memory_access
